// ### rtl/bst_tap.sv
// Purpose: Boundary-scan test access port controller.
// Assumes: Test clock well below the 100 MHz system clock.
// Notes:   Test clock edges are found by sampling; no edge, no change.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - A low on the test reset pin forces the test logic to reset at once.
// - Mode select is sampled on each rising test clock edge to step the FSM.
// - Serial input bits are captured on the rising test clock edge.
// - Serial output changes on the falling test clock edge.
// - Serial output is driven only while shifting, else released.
// - All test state holds while the test clock stands low.
// - Undriven reset, mode select and data inputs read as high.
module bst_tap
  import bst_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       trst_n_i,
  input  wire logic       tck_i,
  input  wire logic       tms_i,
  input  wire logic       tms_oe_i,
  input  wire logic       tdi_i,
  input  wire logic       tdi_oe_i,
  input  wire logic       trst_oe_i,
  input  wire logic [bst_pkg::BSR_LEN-1:0] pins_i,
  output var  logic       tdo_o,
  output var  logic       tdo_oe_o,
  output var  logic [bst_pkg::BSR_LEN-1:0] pins_o,
  output var  logic       extest_o,
  output var  logic [3:0] state_o
);
  import bst_pkg::*;

  logic       trst_eff, tms_eff, tdi_eff;
  logic       arst_n;
  logic [2:0] synced;
  logic       tck_q;
  logic       rise, fall;
  bst_state_e state, next_state;
  logic [IR_LEN-1:0]     ir_sh, ir;
  logic [BSR_LEN-1:0]    bsr_sh;
  logic [IDCODE_LEN-1:0] id_sh;
  logic                  byp;
  logic                  tdo_next, shifting;

  // Pull-ups: an undriven input reads high.
  assign trst_eff = trst_oe_i ? trst_n_i : 1'b1;
  assign tms_eff  = tms_oe_i ? tms_i : 1'b1;
  assign tdi_eff  = tdi_oe_i ? tdi_i : 1'b1;
  // Test reset acts without any clock. System reset is synchronous and is
  // kept off this path, so system-domain logic never drives a clear.
  assign arst_n   = trst_eff;

  bst_sync #(.WIDTH(3), .INIT(1'b0)) u_sync (
    .clock_i  (clock_i),
    .arst_n_i (arst_n),
    .d_i      ({tck_i, tms_eff, tdi_eff}),
    .q_o      (synced)
  );

  // The edge finder resets to the idle low level of the test clock pin,
  // so no false edge follows a reset.
  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      tck_q <= 1'b0;
    end else begin
      tck_q <= synced[2];
    end
  end

  // Nothing moves without a test clock edge, so state holds while idle.
  assign rise = synced[2] & ~tck_q;
  assign fall = ~synced[2] & tck_q;

  always_comb begin
    next_state = state;
    case (state)
      BST_RESET:  next_state = synced[1] ? BST_RESET  : BST_IDLE;
      BST_IDLE:   next_state = synced[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_DR: next_state = synced[1] ? BST_SEL_IR : BST_CAP_DR;
      BST_CAP_DR: next_state = synced[1] ? BST_EX1_DR : BST_SH_DR;
      BST_SH_DR:  next_state = synced[1] ? BST_EX1_DR : BST_SH_DR;
      BST_EX1_DR: next_state = synced[1] ? BST_UPD_DR : BST_PA_DR;
      BST_PA_DR:  next_state = synced[1] ? BST_EX2_DR : BST_PA_DR;
      BST_EX2_DR: next_state = synced[1] ? BST_UPD_DR : BST_SH_DR;
      BST_UPD_DR: next_state = synced[1] ? BST_SEL_DR : BST_IDLE;
      BST_SEL_IR: next_state = synced[1] ? BST_RESET  : BST_CAP_IR;
      BST_CAP_IR: next_state = synced[1] ? BST_EX1_IR : BST_SH_IR;
      BST_SH_IR:  next_state = synced[1] ? BST_EX1_IR : BST_SH_IR;
      BST_EX1_IR: next_state = synced[1] ? BST_UPD_IR : BST_PA_IR;
      BST_PA_IR:  next_state = synced[1] ? BST_EX2_IR : BST_PA_IR;
      BST_EX2_IR: next_state = synced[1] ? BST_UPD_IR : BST_SH_IR;
      BST_UPD_IR: next_state = synced[1] ? BST_SEL_DR : BST_IDLE;
      default:    next_state = BST_RESET;
    endcase
  end

  // The state moves on a found rising edge only. The two-flop delay costs
  // about three system clocks of reaction, which is why each test clock
  // phase must last at least that long.
  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      state <= BST_RESET;
    end else if (srst_i) begin
      state <= BST_RESET;
    end else if (rise) begin
      state <= next_state;
    end
  end

  // Instruction path; the reset state selects the identification code.
  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      ir_sh <= IR_RESET;
      ir    <= IR_IDCODE;
    end else if (srst_i) begin
      ir_sh <= IR_RESET;
      ir    <= IR_IDCODE;
    end else if (rise) begin
      case (state)
        BST_RESET:  ir <= IR_IDCODE;
        BST_CAP_IR: ir_sh <= IR_CAPTURE;
        BST_SH_IR:  ir_sh <= {tdi_eff_s(), ir_sh[IR_LEN-1:1]};
        BST_UPD_IR: ir <= ir_sh;
        default:    ir <= ir;
      endcase
    end
  end

  function automatic logic tdi_eff_s();
    return synced[0];
  endfunction : tdi_eff_s

  // Both boundary instructions share the one boundary register.
  function automatic logic bsr_sel(input logic [IR_LEN-1:0] code);
    return (code == IR_EXTEST) || (code == IR_SAMPLE);
  endfunction : bsr_sel

  // Data registers chosen by the current instruction.
  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      bsr_sh <= '0;
      id_sh  <= '0;
      byp    <= 1'b0;
      pins_o <= '0;
    end else if (srst_i) begin
      bsr_sh <= '0;
      id_sh  <= '0;
      byp    <= 1'b0;
      pins_o <= '0;
    end else if (rise) begin
      case (state)
        BST_CAP_DR: begin
          bsr_sh <= pins_i;
          id_sh  <= IDCODE_VALUE;
          byp    <= 1'b0;
        end
        BST_SH_DR: begin
          case (ir)
            IR_EXTEST, IR_SAMPLE:
              bsr_sh <= {tdi_eff_s(), bsr_sh[BSR_LEN-1:1]};
            IR_IDCODE:
              id_sh <= {tdi_eff_s(), id_sh[IDCODE_LEN-1:1]};
            default: byp <= tdi_eff_s();
          endcase
        end
        BST_UPD_DR: begin
          if (bsr_sel(ir)) begin
            pins_o <= bsr_sh;
          end
        end
        default: byp <= byp;
      endcase
    end
  end

  always_comb begin
    if (bsr_sel(ir)) begin
      tdo_next = bsr_sh[0];
    end else if (ir == IR_IDCODE) begin
      tdo_next = id_sh[0];
    end else begin
      tdo_next = byp;
    end
    if (state == BST_SH_IR) begin
      tdo_next = ir_sh[0];
    end
  end

  assign shifting = (state == BST_SH_DR) || (state == BST_SH_IR);

  // Output moves on the falling edge, giving the tester half a period.
  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (srst_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (fall) begin
      tdo_o    <= tdo_next;
      tdo_oe_o <= shifting;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n) begin
    if (!arst_n) begin
      extest_o <= 1'b0;
      state_o  <= 4'h0;
    end else if (srst_i) begin
      extest_o <= 1'b0;
      state_o  <= 4'h0;
    end else begin
      extest_o <= (ir == IR_EXTEST);
      state_o  <= 4'(state);
    end
  end
endmodule : bst_tap
`default_nettype wire

// ### rtl/bst_pkg.sv
// Purpose: Constants for the boundary-scan test port.
// Assumes: Test clock sampled by the 100 MHz system clock.
// Notes:   Instruction codes and register lengths are plain defaults.
package bst_pkg;
  localparam int          IR_LEN        = 4;
  localparam int          BSR_LEN       = 16;
  localparam int          IDCODE_LEN    = 32;
  localparam logic [3:0]  IR_RESET      = 4'h1;
  localparam logic [3:0]  IR_EXTEST     = 4'h0;
  localparam logic [3:0]  IR_SAMPLE     = 4'h2;
  localparam logic [3:0]  IR_IDCODE     = 4'h1;
  localparam logic [3:0]  IR_BYPASS     = 4'hf;
  localparam logic [3:0]  IR_CAPTURE    = 4'h1;
  // Arbitrary identification value, not tied to any real part.
  localparam logic [31:0] IDCODE_VALUE  = 32'h1234_5677;

  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR,
    BST_PA_DR, BST_EX2_DR, BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR,
    BST_EX1_IR, BST_PA_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_e;
endpackage : bst_pkg

// ### rtl/bst_sync.sv
// Purpose: Two-flop synchroniser with asynchronous preset.
// Assumes: Input from outside the system clock domain.
// Notes:   The first flop feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module bst_sync #(
  parameter int  WIDTH = 1,
  parameter logic INIT = 1'b1
) (
  input  wire logic             clock_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output var  logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= {WIDTH{INIT}};
      q_o  <= {WIDTH{INIT}};
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule : bst_sync
`default_nettype wire

// ### dv/bst_tap_properties.sv
// Purpose: Port checks for bst_tap.
// Assumes: Test clock phases last 4 or more system clocks.
// Notes:   lo counts system clocks of test clock low.
`timescale 1ns/1ps
`default_nettype none
module bst_tap_chk
  import bst_pkg::*;
(
  input wire logic         clock_i,
  input wire logic         srst_i,
  input wire logic         trst_n_i,
  input wire logic         tck_i,
  input wire logic         tdo_o,
  input wire logic         tdo_oe_o,
  input wire logic         extest_o,
  input wire logic [3:0]   state_o,
  input wire logic [BSR_LEN-1:0] pins_o
);
  logic [3:0] lo;
  always_ff @(posedge clock_i) begin
    lo <= (tck_i || srst_i) ? 4'h0 : lo + 4'(lo != 4'hf);
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i || !trst_n_i);
  sequence s_left(logic [3:0] st);
    $changed(state_o) && $past(state_o) == st;
  endsequence
  property p_trst;
    disable iff (srst_i) !trst_n_i |=> state_o == 4'h0 && !tdo_oe_o;
  endproperty
  a_trst: assert property (p_trst) else $error("trst");
  property p_hold;
    (!tck_i)[*8] |-> $stable(state_o) && $stable(tdo_o) && $stable(pins_o);
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_step; $changed(state_o) |-> lo == 4'h0; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_fall;
    $changed(tdo_o) || $changed(tdo_oe_o) |-> lo != 4'h0;
  endproperty
  a_fall: assert property (p_fall) else $error("fall");
  property p_oe;
    tdo_oe_o |-> state_o inside {BST_SH_DR, BST_EX1_DR, BST_SH_IR, BST_EX1_IR};
  endproperty
  a_oe: assert property (p_oe) else $error("oe");
  property p_idle; s_left(BST_RESET) |-> state_o == BST_IDLE; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_shdr; s_left(BST_SH_DR) |-> state_o == BST_EX1_DR; endproperty
  a_shdr: assert property (p_shdr) else $error("shdr");
  property p_ext;
    $changed(extest_o) |-> $past(state_o) inside {BST_UPD_IR, BST_RESET};
  endproperty
  a_ext: assert property (p_ext) else $error("ext");
endmodule : bst_tap_chk
bind bst_tap bst_tap_chk chk (
  .clock_i  (clock_i),
  .srst_i   (srst_i),
  .trst_n_i (trst_n_i),
  .tck_i    (tck_i),
  .tdo_o    (tdo_o),
  .tdo_oe_o (tdo_oe_o),
  .extest_o (extest_o),
  .state_o  (state_o),
  .pins_o   (pins_o)
);
`default_nettype wire

// ### dv/bst_tester.sv
// Purpose: Tester model driving the test port pins.
// Assumes: Pins move only at falling system clock edges.
// Notes:   Test clock runs only inside step, 80 ns a bit.
`timescale 1ns/1ps
`default_nettype none
module bst_tester (
  input  wire logic clock_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  output var  logic tck_o,
  output var  logic tms_o,
  output var  logic tms_oe_o,
  output var  logic tdi_o,
  output var  logic tdi_oe_o,
  output var  logic trst_n_o,
  output var  logic trst_oe_o
);
  initial begin
    {tck_o, tms_o, tdi_o, trst_n_o} = 4'h6;
    {tms_oe_o, tdi_oe_o, trst_oe_o} = 3'h7;
  end
  // A released line toggles, so only the pull-up gives a steady 1.
  task automatic step(input logic ms, input logic di,
                      output logic do_, output logic oe);
    @(negedge clock_i);
    tms_o = tms_oe_o ? ms : !tms_o;
    tdi_o = tdi_oe_o ? di : !tdi_o;
    repeat (3) @(negedge clock_i);
    do_ = tdo_i;
    oe = tdo_oe_i;
    tck_o = 1'b1;
    repeat (4) @(negedge clock_i);
    tck_o = 1'b0;
  endtask : step
  task automatic drive_tms(input logic en);
    @(negedge clock_i);
    tms_oe_o = en;
  endtask : drive_tms
  task automatic drive_tdi(input logic en);
    @(negedge clock_i);
    tdi_oe_o = en;
  endtask : drive_tdi
  task automatic reset_port(input int n);
    @(negedge clock_i);
    tms_o = 1'b1;
    trst_n_o = 1'b0;
    repeat (n) @(negedge clock_i);
    trst_n_o = 1'b1;
  endtask : reset_port
endmodule : bst_tester
`default_nettype wire

// ### dv/bst_tap_tb.sv
// Purpose: Self-checking bench for bst_tap.
// Assumes: The tester model owns all test port pins.
// Notes:   Runs about 13 us.
`timescale 1ns/1ps
`default_nettype none
module bst_tap_tb;
  import bst_pkg::*;
  logic clock_i, srst_i, tck, tms, ms_oe, tdi, di_oe, rst_n, rst_oe;
  logic tdo, tdo_oe, extest;
  logic [3:0] state;
  logic [15:0] pins_o;
  logic [31:0] dout;
  int num_errors = 0;
  int tests_run = 0;
  bst_tap dut (.clock_i, .srst_i, .trst_n_i(rst_n), .tck_i(tck),
    .tms_i(tms), .tms_oe_i(ms_oe), .tdi_i(tdi), .tdi_oe_i(di_oe),
    .trst_oe_i(rst_oe), .pins_i(16'ha5c3), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .pins_o, .extest_o(extest), .state_o(state));
  bst_tester t (.clock_i, .tdo_i(tdo), .tdo_oe_i(tdo_oe), .tck_o(tck),
    .tms_o(tms), .tms_oe_o(ms_oe), .tdi_o(tdi), .tdi_oe_o(di_oe),
    .trst_n_o(rst_n), .trst_oe_o(rst_oe));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic walk(input logic [7:0] ms, input int n);
    logic d, o;
    for (int i = 0; i < n; i++) t.step(ms[i], 1'b0, d, o);
  endtask : walk
  task automatic scan(input int n, input logic [31:0] din);
    logic d, o;
    dout = '0;
    for (int i = 0; i < n; i++) begin
      t.step(i == n - 1, din[i], d, o);
      dout[i] = d;
      chk(32'(o), 32'h1);
    end
  endtask : scan
  task automatic t_idcode;
    walk(8'h1f, 6);
    walk(8'h01, 3);
    chk(32'(state), 32'(BST_SH_DR));
    scan(32, 32'h0);
    chk(dout, IDCODE_VALUE);
    walk(8'h01, 2);
    chk(32'(tdo_oe), 32'h0);
  endtask : t_idcode
  task automatic t_extest;
    walk(8'h03, 4);
    scan(4, 32'(IR_EXTEST));
    chk(32'(dout[3:0]), 32'(IR_CAPTURE));
    walk(8'h01, 2);
    chk(32'(extest), 32'h1);
    walk(8'h01, 3);
    scan(16, 32'h3c5a);
    chk(32'(dout[15:0]), 32'ha5c3);
    walk(8'h01, 2);
    chk(32'(pins_o), 32'h3c5a);
  endtask : t_extest
  task automatic t_hold;
    repeat (60) @(negedge clock_i);
    chk(32'(state), 32'(BST_IDLE));
  endtask : t_hold
  task automatic t_pullup;
    t.drive_tms(1'b0);
    walk(8'h00, 5);
    chk(32'(state), 32'(BST_RESET));
    chk(32'(extest), 32'h0);
    t.drive_tms(1'b1);
    walk(8'h02, 4);
    t.drive_tdi(1'b0);
    scan(32, 32'h0);
    chk(dout, IDCODE_VALUE);
    walk(8'h02, 3);
    scan(32, 32'h0);
    chk(dout, 32'hffff_ffff);
    walk(8'h01, 2);
    t.drive_tdi(1'b1);
  endtask : t_pullup
  task automatic t_trst;
    walk(8'h01, 3);
    repeat (4) @(negedge clock_i);
    chk(32'(tdo_oe), 32'h1);
    t.reset_port(3);
    chk(32'({state, tdo_oe}), 32'h0);
  endtask : t_trst
  task automatic wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    srst_i = 1'b1;
    repeat (6) @(negedge clock_i);
    srst_i = 1'b0;
    t.reset_port(2);
    repeat (4) @(negedge clock_i);
    chk(32'({state, tdo_oe}), 32'h0);
    t_idcode();
    t_extest();
    t_hold();
    t_pullup();
    t_trst();
    wrap_up();
  end
  initial begin
    #40000;
    num_errors++;
    wrap_up();
  end
endmodule : bst_tap_tb
`default_nettype wire
